// File: hw/sar_pkg.sv
// shared constants, bit positions and state type of the 8-bit approximation sequencer
package sar_pkg;

    // ------------------------------------------------------------------
    // word size and control port bit positions
    // ------------------------------------------------------------------
    localparam int NBITS        = 8;
    localparam int CTL_COMP_BIT = 7;
    localparam int CTL_SCK_BIT  = 5;
    localparam int CTL_DONE_BIT = 4;
    localparam int CTL_SER_BIT  = 3;
    localparam int CTL_REQ_BIT  = 1;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] DAC_RST = 8'h00;
    localparam logic [7:0] CTL_RST = 8'h10;
    localparam logic [7:0] RES_RST = 8'h00;

    // ------------------------------------------------------------------
    // timing: printed figures, then cycle counts at the system clock
    // ------------------------------------------------------------------
    localparam int CLK_MHZ    = 200;
    localparam int CONV_NS    = 700000;
    localparam int SETTLE_NS  = 8000;
    localparam int PULSE_NS   = 7000;
    localparam int SETUP_NS   = 5;
    localparam int BIT_NS     = CONV_NS / NBITS;
    localparam int BIT_CYC    = BIT_NS * CLK_MHZ / 1000;
    localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
    localparam int PULSE_CYC  = PULSE_NS * CLK_MHZ / 1000;
    localparam int SETUP_CYC  = (SETUP_NS * CLK_MHZ + 999) / 1000;

    // ------------------------------------------------------------------
    // sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_CLEAR,
        ST_TRIAL
    } seq_state_t;

endpackage

// File: hw/word_stream_if.sv
// valid/ready word channel between the sequencer and its result buffer
`timescale 1ns/1ps
interface word_stream_if #(
    parameter int W = 8
);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// File: hw/result_buffer.sv
// two-entry buffer: an output stage plus one skid entry, all outputs from flops
`timescale 1ns/1ps
module result_buffer #(
    parameter int W = 8
) (
    input  wire logic   clk,
    input  wire logic   rst,
    word_stream_if.snk  fill,
    word_stream_if.src  drain
);

    // ------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------
    logic         out_valid_ff;
    logic [W-1:0] out_data_ff;
    logic         skid_valid_ff;
    logic [W-1:0] skid_data_ff;

    if (W < 1) begin : g_bad_width
        $error("result_buffer width must be at least one");
    end

    // ------------------------------------------------------------------
    // handshake decode
    // ------------------------------------------------------------------
    wire out_free = !out_valid_ff || drain.ready;
    wire take_in  = fill.valid && !skid_valid_ff;

    // ready comes from a flop, so a stalled drain backs up to the source
    assign fill.ready  = !skid_valid_ff;
    assign drain.valid = out_valid_ff;
    assign drain.data  = out_data_ff;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            out_valid_ff  <= 1'b0;
            out_data_ff   <= '0;
            skid_valid_ff <= 1'b0;
            skid_data_ff  <= '0;
        end else if (out_free) begin
            out_valid_ff  <= skid_valid_ff || take_in;
            out_data_ff   <= skid_valid_ff ? skid_data_ff : fill.data;
            skid_valid_ff <= 1'b0;
        end else if (take_in) begin
            skid_valid_ff <= 1'b1;
            skid_data_ff  <= fill.data;
        end
    end

endmodule

// File: hw/sar_adc_sequencer_8bit.sv
// successive approximation sequencer driving a parallel dac and reading a comparator
`timescale 1ns/1ps
module sar_adc_sequencer_8bit #(
    parameter int NBITS      = sar_pkg::NBITS,
    parameter int BIT_CYC    = sar_pkg::BIT_CYC,
    parameter int SETTLE_CYC = sar_pkg::SETTLE_CYC,
    parameter int SETUP_CYC  = sar_pkg::SETUP_CYC,
    parameter int PULSE_CYC  = sar_pkg::PULSE_CYC
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [7:0]       adc_control_in,
    output logic      [7:0]       adc_control_port,
    output logic      [NBITS-1:0] dac_word_port,
    output logic                  sim_bit_clock,
    output logic                  conv_done_flag,
    output logic                  serial_result_out,
    output logic      [NBITS-1:0] result_hold,
    output logic                  result_valid,
    output logic      [NBITS-1:0] result_data,
    input  wire logic             result_ready
);

    // ------------------------------------------------------------------
    // elaboration checks and timer constants
    // ------------------------------------------------------------------
    localparam int TW = $clog2(BIT_CYC + 1);

    if (NBITS < 2 || NBITS > 8) begin : g_bad_bits
        $error("sequencer word must be 2 to 8 bits wide");
    end
    if (SETTLE_CYC < 1 || SETUP_CYC < 1 || PULSE_CYC < 1) begin : g_bad_min
        $error("settle, setup and pulse counts must be at least one");
    end
    if (SETTLE_CYC + SETUP_CYC + PULSE_CYC >= BIT_CYC) begin : g_bad_period
        $error("settle, setup and pulse do not fit in one bit period");
    end

    // decision, clock edges and bit end sit at fixed timer values
    localparam logic [TW-1:0] T_DECIDE = TW'(SETTLE_CYC);
    localparam logic [TW-1:0] T_RISE   = TW'(SETTLE_CYC + SETUP_CYC);
    localparam logic [TW-1:0] T_FALL   = TW'(SETTLE_CYC + SETUP_CYC + PULSE_CYC);
    localparam logic [TW-1:0] T_END    = TW'(BIT_CYC - 1);
    localparam logic [NBITS-1:0] MSB_MARK = {1'b1, {(NBITS-1){1'b0}}};

    // ------------------------------------------------------------------
    // pin synchronisers: comparator and request arrive from outside
    // ------------------------------------------------------------------
    logic [1:0] pin_s1_ff;
    logic [1:0] pin_s2_ff;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_s1_ff <= 2'h0;
            pin_s2_ff <= 2'h0;
        end else begin
            pin_s1_ff <= {adc_control_in[sar_pkg::CTL_COMP_BIT],
                          adc_control_in[sar_pkg::CTL_REQ_BIT]};
            pin_s2_ff <= pin_s1_ff;
        end
    end

    wire cmp_s = pin_s2_ff[1];
    wire req_s = pin_s2_ff[0];

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    sar_pkg::seq_state_t state_ff;
    sar_pkg::seq_state_t nxt_state;
    logic [TW-1:0]       tmr_ff;
    logic [TW-1:0]       nxt_tmr;
    logic [NBITS-1:0]    dac_ff;
    logic [NBITS-1:0]    nxt_dac;
    logic [NBITS-1:0]    marker_ff;
    logic [NBITS-1:0]    nxt_marker;
    logic [NBITS-1:0]    res_ff;
    logic [NBITS-1:0]    nxt_res;
    logic [7:0]          ctl_ff;
    logic [7:0]          nxt_ctl;
    logic                push_ff;
    logic                nxt_push;

    word_stream_if #(.W(NBITS)) fill_ch ();
    word_stream_if #(.W(NBITS)) drain_ch ();

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    wire in_trial  = (state_ff == sar_pkg::ST_TRIAL);
    wire at_decide = in_trial && (tmr_ff == T_DECIDE);
    wire at_rise   = in_trial && (tmr_ff == T_RISE);
    wire at_fall   = in_trial && (tmr_ff == T_FALL);
    wire at_end    = in_trial && (tmr_ff == T_END);
    wire last_bit  = marker_ff[0];

    // a new conversion waits while the buffer is full or the previous result is still being pushed
    wire start_ok  = (state_ff == sar_pkg::ST_IDLE) && req_s
                     && fill_ch.ready && !push_ff;

    // comparator high keeps the bit, low drops it
    wire [NBITS-1:0] kept_word = cmp_s ? dac_ff : (dac_ff & ~marker_ff);
    wire [NBITS-1:0] next_mark = marker_ff >> 1;

    // ------------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        nxt_state  = state_ff;
        nxt_tmr    = tmr_ff;
        nxt_dac    = dac_ff;
        nxt_marker = marker_ff;
        nxt_res    = res_ff;
        nxt_ctl    = ctl_ff;
        nxt_push   = push_ff && !fill_ch.ready;
        case (state_ff)
            sar_pkg::ST_IDLE: begin
                nxt_ctl[sar_pkg::CTL_DONE_BIT] = 1'b1;
                if (start_ok) begin
                    nxt_state  = sar_pkg::ST_CLEAR;
                    nxt_dac    = '0;
                    nxt_marker = '0;
                    nxt_ctl[sar_pkg::CTL_DONE_BIT] = 1'b0;
                end
            end
            sar_pkg::ST_CLEAR: begin
                nxt_state  = sar_pkg::ST_TRIAL;
                nxt_tmr    = '0;
                nxt_dac    = MSB_MARK;
                nxt_marker = MSB_MARK;
            end
            sar_pkg::ST_TRIAL: begin
                nxt_tmr = tmr_ff + TW'(1);
                // the comparator is read only after the settle count
                if (at_decide) begin
                    nxt_dac = kept_word;
                    nxt_res = kept_word;
                    nxt_ctl[sar_pkg::CTL_SER_BIT] = cmp_s;
                end
                // data was set one setup count earlier and holds past the fall
                if (at_rise) begin
                    nxt_ctl[sar_pkg::CTL_SCK_BIT] = 1'b1;
                end
                if (at_fall) begin
                    nxt_ctl[sar_pkg::CTL_SCK_BIT] = 1'b0;
                end
                // each bit takes the full period whatever was decided
                if (at_end) begin
                    nxt_tmr    = '0;
                    nxt_marker = next_mark;
                    if (last_bit) begin
                        nxt_state = sar_pkg::ST_IDLE;
                        nxt_ctl[sar_pkg::CTL_DONE_BIT] = 1'b1;
                        nxt_push  = 1'b1;
                    end else begin
                        nxt_dac = dac_ff | next_mark;
                    end
                end
            end
            default: begin
                nxt_state = sar_pkg::ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff  <= sar_pkg::ST_IDLE;
            tmr_ff    <= '0;
            dac_ff    <= NBITS'(sar_pkg::DAC_RST);
            marker_ff <= '0;
            res_ff    <= NBITS'(sar_pkg::RES_RST);
            ctl_ff    <= sar_pkg::CTL_RST;
            push_ff   <= 1'b0;
        end else begin
            state_ff  <= nxt_state;
            tmr_ff    <= nxt_tmr;
            dac_ff    <= nxt_dac;
            marker_ff <= nxt_marker;
            res_ff    <= nxt_res;
            ctl_ff    <= nxt_ctl;
            push_ff   <= nxt_push;
        end
    end

    // ------------------------------------------------------------------
    // result buffer: a stalled receiver holds off conversions once both entries are full
    // ------------------------------------------------------------------
    assign fill_ch.valid  = push_ff;
    assign fill_ch.data   = res_ff;
    assign drain_ch.ready = result_ready;

    result_buffer #(.W(NBITS)) u_result_buffer (
        .clk   (clk),
        .rst   (rst),
        .fill  (fill_ch),
        .drain (drain_ch)
    );

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign dac_word_port     = dac_ff;
    assign adc_control_port  = ctl_ff;
    assign sim_bit_clock     = ctl_ff[sar_pkg::CTL_SCK_BIT];
    assign conv_done_flag    = ctl_ff[sar_pkg::CTL_DONE_BIT];
    assign serial_result_out = ctl_ff[sar_pkg::CTL_SER_BIT];
    assign result_hold       = res_ff;
    assign result_valid      = drain_ch.valid;
    assign result_data       = drain_ch.data;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    localparam int PULSE_LEN = PULSE_CYC;
    localparam int CONV_LEN  = NBITS * BIT_CYC + 1;

    int hi_cnt_ff;
    int busy_cnt_ff;

    // helper counters: high run of the bit clock, low run of the finished flag
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hi_cnt_ff   <= 0;
            busy_cnt_ff <= 0;
        end else begin
            hi_cnt_ff   <= sim_bit_clock ? hi_cnt_ff + 1 : 0;
            busy_cnt_ff <= conv_done_flag ? 0 : busy_cnt_ff + 1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_idle_done;
        state_ff == sar_pkg::ST_IDLE |-> conv_done_flag;
    endproperty
    a_idle_done: assert property (p_idle_done)
        else $error("finished flag low while idle");

    property p_busy_flag;
        state_ff != sar_pkg::ST_IDLE |-> !conv_done_flag;
    endproperty
    a_busy_flag: assert property (p_busy_flag)
        else $error("finished flag high during a conversion");

    property p_clear_first;
        start_ok |=> dac_word_port == '0 && marker_ff == '0
                     ##1 dac_word_port == MSB_MARK;
    endproperty
    a_clear_first: assert property (p_clear_first)
        else $error("conversion did not clear then set the msb");

    property p_decide;
        at_decide |=> ((dac_word_port & $past(marker_ff))
                       == ($past(cmp_s) ? $past(marker_ff) : '0))
                      && serial_result_out == $past(cmp_s)
                      && result_hold == dac_word_port;
    endproperty
    a_decide: assert property (p_decide)
        else $error("bit decision, serial bit or held result wrong");

    property p_shift;
        at_end && !last_bit |=> marker_ff == ($past(marker_ff) >> 1)
                                && (dac_word_port & marker_ff) == marker_ff;
    endproperty
    a_shift: assert property (p_shift)
        else $error("marker did not move to the next lower bit");

    property p_settle;
        $changed(serial_result_out) |-> $past(tmr_ff) == T_DECIDE;
    endproperty
    a_settle: assert property (p_settle)
        else $error("serial bit changed outside the decision point");

    property p_sd_hold;
        sim_bit_clock |-> $stable(serial_result_out);
    endproperty
    a_sd_hold: assert property (p_sd_hold)
        else $error("serial data moved while the bit clock was high");

    property p_pulse_len;
        $fell(sim_bit_clock) |-> hi_cnt_ff == PULSE_LEN;
    endproperty
    a_pulse_len: assert property (p_pulse_len)
        else $error("bit clock pulse width wrong");

    property p_conv_len;
        $rose(conv_done_flag) |-> busy_cnt_ff == CONV_LEN;
    endproperty
    a_conv_len: assert property (p_conv_len)
        else $error("conversion length wrong");

    property p_ctl_map;
        adc_control_port[7:6] == 2'h0 && adc_control_port[2:0] == 3'h0;
    endproperty
    a_ctl_map: assert property (p_ctl_map)
        else $error("unused control port bit driven");

    property p_wait_req;
        state_ff == sar_pkg::ST_IDLE && !req_s |=> state_ff == sar_pkg::ST_IDLE;
    endproperty
    a_wait_req: assert property (p_wait_req)
        else $error("conversion started without a request");

    property p_low_bits_off;
        in_trial |-> (dac_word_port & (marker_ff - NBITS'(1))) == '0;
    endproperty
    a_low_bits_off: assert property (p_low_bits_off)
        else $error("dac bit below the trial bit is on");

    property p_idle_hold;
        state_ff == sar_pkg::ST_IDLE |-> result_hold == dac_word_port;
    endproperty
    a_idle_hold: assert property (p_idle_hold)
        else $error("held result differs from the dac word in idle");

    c_full_conv: cover property ($rose(conv_done_flag));
    c_keep_bit: cover property (at_decide && cmp_s);
    c_drop_bit: cover property (at_decide && !cmp_s);
    c_stalled: cover property (state_ff == sar_pkg::ST_IDLE && req_s && !fill_ch.ready);

endmodule

// File: tb/dac_comparator_model.sv
// behavioural dac and comparator that face the sequencer's parallel word
`timescale 1ns/1ps
module dac_comparator_model (
    input  wire logic       clk,
    input  wire logic [7:0] dac_word,
    input  wire logic [8:0] vin_half,
    input  wire logic [3:0] lag,
    output logic            comp
);
    logic [7:0] dac_q  = 8'h00;
    logic [3:0] age    = 4'h0;
    logic       target;

    // input is given in half steps so the dac never lands exactly on it;
    // a one on a word bit switches that bit's current on
    assign target = ({dac_word, 1'b0} < vin_half);

    // an unsettled comparator shows the wrong side until lag cycles have passed
    always @(negedge clk) begin
        if (dac_word !== dac_q)
            age = 4'h0;
        else if (age != 4'hf)
            age = age + 4'h1;
        dac_q = dac_word;
        comp  = (age >= lag) ? target : ~target;
    end
endmodule

// File: tb/tb_sar_adc_sequencer_8bit.sv
// self-checking bench for the approximation sequencer: table rows, then hand cases
`timescale 1ns/1ps
module tb_sar_adc_sequencer_8bit;
    // ------------------------------------------------------------------
    // settings and signals
    // ------------------------------------------------------------------
    localparam int BC    = 40;
    localparam int STL   = 8;
    localparam int UC    = 1;
    localparam int PC    = 7;
    localparam int LIMIT = 3000;

    typedef struct packed {
        logic [8:0] vin;
        logic [3:0] lag;
        logic [7:0] word;
    } row_t;

    row_t rows [8] = '{
        '{9'h001, 4'h0, 8'h00}, '{9'h1ff, 4'h0, 8'hff}, '{9'h101, 4'h4, 8'h80},
        '{9'h0ff, 4'h4, 8'h7f}, '{9'h0ab, 4'h2, 8'h55}, '{9'h155, 4'h3, 8'haa},
        '{9'h0fd, 4'h4, 8'h7e}, '{9'h103, 4'h1, 8'h81}};

    logic       clk, rst, req, ready, comp, sck, done, ser, valid;
    logic [7:0] ctl_drv, ctl_port, dac, hold, data, exp_word, mask, dac_q;
    logic [8:0] vin;
    logic [3:0] lag;
    logic       sck_q, done_q, ser_q;
    int         error_cnt, n_tests, low_cnt, pulses, pw;

    sar_adc_sequencer_8bit #(.BIT_CYC(BC), .SETTLE_CYC(STL), .SETUP_CYC(UC), .PULSE_CYC(PC))
    u_sar_adc_sequencer_8bit (
        .clk(clk), .rst(rst), .adc_control_in({comp, ctl_drv[6:2], req, ctl_drv[0]}),
        .adc_control_port(ctl_port), .dac_word_port(dac), .sim_bit_clock(sck),
        .conv_done_flag(done), .serial_result_out(ser), .result_hold(hold),
        .result_valid(valid), .result_data(data), .result_ready(ready));

    dac_comparator_model u_dac_comparator_model (
        .clk(clk), .dac_word(dac), .vin_half(vin), .lag(lag), .comp(comp));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // ------------------------------------------------------------------
    // compare, wait and closing tasks
    // ------------------------------------------------------------------
    task automatic chk_word(input string what, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic chk_cnt(input string what, input int e, input int g);
        n_tests++;
        if (g != e) begin
            error_cnt++;
            $display("MISMATCH %s expected %0d seen %0d", what, e, g);
        end
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // bounded wait at falling edges until the flag shows the wanted level
    task automatic wait_for(ref logic sig, input logic lvl, input string what);
        int i;
        for (i = 0; i < LIMIT && sig !== lvl; i++)
            @(negedge clk);
        if (sig !== lvl) begin
            error_cnt++;
            $display("MISMATCH wait for %s expected %b seen %b", what, lvl, sig);
            give_verdict();
        end
    endtask

    task automatic set_input(input row_t r);
        vin      = r.vin;
        lag      = r.lag;
        exp_word = r.word;
    endtask

    task automatic take_result(input logic [7:0] e);
        wait_for(valid, 1'b1, "result valid");
        chk_word("result data", e, data);
        @(negedge clk);
    endtask

    task automatic run_conv(input row_t r);
        set_input(r);
        req = 1'b1;
        wait_for(done, 1'b0, "done fall");
        req = 1'b0;
        wait_for(done, 1'b1, "done rise");
        chk_word("final hold", r.word, hold);
        chk_word("final dac", r.word, dac);
        take_result(r.word);
    endtask

    task automatic chk_reset();
        chk_word("reset dac", 8'h00, dac);
        chk_word("reset control", 8'h10, ctl_port);
        chk_word("reset hold", 8'h00, hold);
        chk_word("reset valid", 8'h00, {7'h00, valid});
    endtask

    // ------------------------------------------------------------------
    // monitor: sampled at falling edges, where outputs have settled
    // ------------------------------------------------------------------
    always @(negedge clk) begin
        if (rst) begin
            low_cnt = 0;
            pulses  = 0;
            pw      = 0;
            sck_q   = 1'b0;
            done_q  = 1'b1;
            dac_q   = 8'h00;
        end else begin
            chk_word("control image", {2'b00, sck, done, ser, 3'b000}, ctl_port);
            if (done === 1'b0) begin
                if (low_cnt == 0)
                    chk_word("cleared dac", 8'h00, dac);
                low_cnt++;
            end
            if (pulses == 0 && done === 1'b0 && dac_q === 8'h00 && dac !== 8'h00)
                chk_word("first trial", 8'h80, dac);
            if (sck === 1'b1 && sck_q === 1'b0 && pulses < 8) begin
                mask = 8'hff << (7 - pulses);
                chk_word("serial bit", {7'h00, exp_word[7-pulses]}, {7'h00, ser});
                chk_word("dac after decision", exp_word & mask, dac);
                chk_word("hold after decision", exp_word & mask, hold);
                ser_q = ser;
                pw   = 0;
                pulses++;
            end
            if (sck === 1'b1) begin
                pw++;
                chk_word("serial steady", {7'h00, ser_q}, {7'h00, ser});
            end
            if (sck_q === 1'b1 && sck === 1'b0)
                chk_cnt("pulse width", PC, pw);
            if (done_q === 1'b0 && done === 1'b1) begin
                chk_cnt("busy cycles", 1 + 8 * BC, low_cnt);
                chk_cnt("pulses", 8, pulses);
                low_cnt = 0;
                pulses  = 0;
            end
            sck_q  = sck;
            done_q = done;
            dac_q  = dac;
        end
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        error_cnt = 0;
        n_tests   = 0;
        rst       = 1'b1;
        req       = 1'b0;
        ready     = 1'b1;
        ctl_drv   = 8'h00;
        set_input(rows[0]);
        repeat (4) @(negedge clk);
        chk_reset();
        rst = 1'b0;
        $display("test reset done");

        // every pin but the request and comparator ones high: no conversion may start
        ctl_drv = 8'h7d;
        repeat (20) @(negedge clk);
        chk_word("idle done", 8'h01, {7'h00, done});
        ctl_drv = 8'h00;
        $display("test ignored pins done");

        foreach (rows[i])
            run_conv(rows[i]);
        $display("test table done");

        // receiver stalls: two words fill the buffer and the third start waits
        ready = 1'b0;
        set_input(rows[4]);
        req = 1'b1;
        wait_for(done, 1'b0, "first start");
        wait_for(done, 1'b1, "first end");
        set_input(rows[5]);
        wait_for(done, 1'b0, "second start");
        wait_for(done, 1'b1, "second end");
        set_input(rows[2]);
        repeat (2 * BC) @(negedge clk);
        chk_word("full buffer holds off", 8'h01, {7'h00, done});
        chk_word("oldest word", rows[4].word, data);
        ready = 1'b1;
        take_result(rows[4].word);
        take_result(rows[5].word);
        wait_for(done, 1'b0, "third start");
        req = 1'b0;
        wait_for(done, 1'b1, "third end");
        take_result(rows[2].word);
        $display("test stalled receiver done");

        // reset in mid conversion, then a clean conversion
        set_input(rows[3]);
        req = 1'b1;
        wait_for(done, 1'b0, "start before reset");
        req = 1'b0;
        repeat (100) @(negedge clk);
        // two edges so the monitor surely sees reset and drops its counts
        rst = 1'b1;
        repeat (2) @(negedge clk);
        chk_reset();
        rst = 1'b0;
        run_conv(rows[6]);
        $display("test mid reset done");
        give_verdict();
    end
endmodule
